// [design/watchdog_cfg.svh]
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

// Register addresses
`define WD_ADDR_CTL    12'hff0
`define WD_ADDR_UPPER  12'hff1
`define WD_ADDR_HIGH   12'hff2
`define WD_ADDR_LOW    12'hff3

// Unlock codes
`define WD_UNLOCK_1    8'h55
`define WD_UNLOCK_2    8'haa

// Reload reset value
`define WD_RELOAD_RST  24'h000400

// Count thresholds
`define WD_NO_REFRESH  24'h000002
`define WD_COUNT_MAX   24'hffffff

// Reset status bit positions
`define WD_STAT_TMO    7
`define WD_STAT_STOP   4

// Timing
`define WD_CLK_HZ      25000000
`define WD_OSC_HZ      10000
`define WD_TICK_CYCLES (`WD_CLK_HZ / `WD_OSC_HZ)

`endif

// [design/watchdog_pkg.sv]
package watchdog_pkg;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'b000,
    LK_GOT55 = 3'b001,
    LK_UPPER = 3'b010,
    LK_HIGH  = 3'b011,
    LK_LOW   = 3'b100
  } lock_e;

  typedef struct packed {
    lock_e       lock;
    logic        started;
    logic        enabled;
    logic [23:0] reload;
    logic [11:0] div;
    logic        tick;
    logic        tmo_flag;
    logic        stop_flag;
    logic        irq;
    logic        sys_reset;
    logic        stop_rec;
    logic [7:0]  rdata;
  } wd_state_s;

  typedef struct packed {
    logic [23:0] count;
  } cnt_state_s;

endpackage

// [design/cnt_if.sv]
interface cnt_if;
  logic        tick;
  logic        en;
  logic        load;
  logic [23:0] load_val;
  logic [23:0] count;

  modport ctl (output tick, en, load, load_val, input count);
  modport ctr (input tick, en, load, load_val, output count);
endinterface

// [design/wd_counter.sv]
`include "watchdog_cfg.svh"

module wd_counter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  cnt_if.ctr        cif
);

  watchdog_pkg::cnt_state_s st;
  watchdog_pkg::cnt_state_s next_st;

  always_comb begin
    next_st = st;
    if (cif.load) begin
      next_st.count = cif.load_val;
    end else if (cif.tick && cif.en) begin
      next_st.count = st.count - 24'h000001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cif.count = st.count;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wrap_to_max_a: assert property (
    (cif.tick && cif.en && !cif.load && st.count == 24'h000000)
      |=> st.count == `WD_COUNT_MAX)
    else $error("Counter did not wrap to all ones");

  load_value_a: assert property (
    cif.load |=> st.count == $past(cif.load_val))
    else $error("Counter did not take the reload value");

endmodule

// [design/watchdog_down_counter.sv]
// How it works
// - Once enabled, counts forever unless refreshed
// - Always-on option starts it after reset
// - 24-bit counter, reload upper/high/low bytes
// - Counts on a 10 kHz tick
// - No refresh once count reaches two
// - First enable loads the reload value
// - Refresh reloads counter, counting resumes
// - Debug mode refreshes continuously
// - Zero count times out; option picks response
// - Interrupt mode raises request, sets flag
// - After interrupt time-out, wraps to all ones
// - Status read clears time-out flag
// - Stop interrupt mode: recovery, request, flags
// - Reset mode forces system reset, sets flag
// - Stop reset mode: recovery, both flags
// - 55, AA, then upper, high, low bytes
// - Unlock writes change no control bits
// - Any stray write relocks sequence
// - Control write-only, reads give reset status
// - Reload byte reads return live count
`include "watchdog_cfg.svh"

module watchdog_down_counter #(
  parameter int TICK_CYCLES = `WD_TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        refresh_i,
  input  wire logic        debug_i,
  input  wire logic        stop_mode_i,
  input  wire logic        always_on_i,
  input  wire logic        response_reset_i,
  input  wire logic [11:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             irq_o,
  output logic             sys_reset_o,
  output logic             stop_recovery_o,
  output logic             enabled_o
);

  if (TICK_CYCLES < 3 || TICK_CYCLES > 4096) begin : bad_tick
    $error("TICK_CYCLES must lie in 3..4096");
  end

  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  watchdog_pkg::wd_state_s st;
  watchdog_pkg::wd_state_s next_st;
  cnt_if                   cif ();

  logic        load;
  logic        timeout;
  logic [23:0] count;

  assign count = cif.count;

  wd_counter counter_u (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif)
  );

  always_comb begin
    load = debug_i
        || (!st.started && always_on_i)
        || (refresh_i && (!st.enabled || count > `WD_NO_REFRESH));
    timeout = st.enabled && st.tick && !load && count == 24'h000001;
  end

  assign cif.tick     = st.tick;
  assign cif.en       = st.enabled;
  assign cif.load     = load;
  assign cif.load_val = st.reload;

  always_comb begin
    next_st           = st;
    next_st.tick      = 1'b0;
    next_st.sys_reset = 1'b0;
    next_st.stop_rec  = 1'b0;
    next_st.started   = 1'b1;

    if (st.div == TICK_LAST) begin
      next_st.div  = 12'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 12'h001;
    end

    if (refresh_i || (!st.started && always_on_i)) begin
      next_st.enabled = 1'b1;
    end

    if (rd_i) begin
      case (addr_i)
        `WD_ADDR_CTL: begin
          next_st.rdata = 8'h00;
          next_st.rdata[`WD_STAT_TMO]  = st.tmo_flag;
          next_st.rdata[`WD_STAT_STOP] = st.stop_flag;
          next_st.tmo_flag  = 1'b0;
          next_st.stop_flag = 1'b0;
        end
        `WD_ADDR_UPPER: next_st.rdata = count[23:16];
        `WD_ADDR_HIGH:  next_st.rdata = count[15:8];
        `WD_ADDR_LOW:   next_st.rdata = count[7:0];
        default:        next_st.rdata = 8'h00;
      endcase
    end

    if (timeout) begin
      next_st.tmo_flag = 1'b1;
      if (stop_mode_i) begin
        next_st.stop_flag = 1'b1;
        next_st.stop_rec  = 1'b1;
      end else if (response_reset_i) begin
        next_st.sys_reset = 1'b1;
      end
    end
    next_st.irq = next_st.tmo_flag && !response_reset_i;

    if (wr_i) begin
      next_st.lock = watchdog_pkg::LK_IDLE;
      if (addr_i == `WD_ADDR_CTL && wdata_i == `WD_UNLOCK_1) begin
        next_st.lock = watchdog_pkg::LK_GOT55;
      end else begin
        case (st.lock)
          watchdog_pkg::LK_GOT55: begin
            if (addr_i == `WD_ADDR_CTL && wdata_i == `WD_UNLOCK_2) begin
              next_st.lock = watchdog_pkg::LK_UPPER;
            end
          end
          watchdog_pkg::LK_UPPER: begin
            if (addr_i == `WD_ADDR_UPPER) begin
              next_st.reload[23:16] = wdata_i;
              next_st.lock          = watchdog_pkg::LK_HIGH;
            end
          end
          watchdog_pkg::LK_HIGH: begin
            if (addr_i == `WD_ADDR_HIGH) begin
              next_st.reload[15:8] = wdata_i;
              next_st.lock         = watchdog_pkg::LK_LOW;
            end
          end
          watchdog_pkg::LK_LOW: begin
            if (addr_i == `WD_ADDR_LOW) begin
              next_st.reload[7:0] = wdata_i;
            end
          end
          default: next_st.lock = watchdog_pkg::LK_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st        <= '0;
      st.lock   <= watchdog_pkg::LK_IDLE;
      st.reload <= `WD_RELOAD_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o         = st.rdata;
  assign irq_o           = st.irq;
  assign sys_reset_o     = st.sys_reset;
  assign stop_recovery_o = st.stop_rec;
  assign enabled_o       = st.enabled;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  stays_enabled_a: assert property (
    st.enabled |=> st.enabled)
    else $error("Watchdog turned itself off");

  always_on_start_a: assert property (
    (!st.started && always_on_i) |=> st.enabled ##1 count == $past(st.reload, 2))
    else $error("Always-on did not start and load");

  refresh_reload_a: assert property (
    (refresh_i && st.enabled && count > 24'h000002)
      |=> count == $past(st.reload))
    else $error("Refresh did not reload counter");

  late_refresh_a: assert property (
    (refresh_i && st.enabled && !debug_i && count != 24'h000000
      && count <= 24'h000002) |=> count <= 24'h000002)
    else $error("Refresh reloaded after count two");

  debug_hold_a: assert property (
    debug_i |=> count == $past(st.reload))
    else $error("Debug mode did not refresh");

  tick_period_a: assert property (
    st.tick |=> !st.tick [*2])
    else $error("Tick came too often");

  irq_timeout_a: assert property (
    (timeout && !response_reset_i) |=> irq_o && st.tmo_flag)
    else $error("Interrupt time-out missed");

  reset_timeout_a: assert property (
    (timeout && response_reset_i && !stop_mode_i)
      |=> sys_reset_o ##1 !sys_reset_o)
    else $error("Reset time-out not a single pulse");

  stop_timeout_a: assert property (
    (timeout && stop_mode_i)
      |=> stop_recovery_o && st.stop_flag && st.tmo_flag)
    else $error("Stop time-out did not recover");

  status_clear_a: assert property (
    (rd_i && addr_i == `WD_ADDR_CTL && !timeout) |=> !st.tmo_flag)
    else $error("Status read did not clear flag");

  reload_guard_a: assert property (
    !$stable(st.reload) |-> $past(wr_i)
      && $past(st.lock) inside {watchdog_pkg::LK_UPPER,
      watchdog_pkg::LK_HIGH, watchdog_pkg::LK_LOW})
    else $error("Reload changed while locked");

  readback_a: assert property (
    (rd_i && addr_i == `WD_ADDR_HIGH) |=> rdata_o == $past(count[15:8]))
    else $error("Readback is not the live count");

  stop_irq_a: assert property (
    (timeout && stop_mode_i && !response_reset_i)
      |=> irq_o && stop_recovery_o && st.stop_flag)
    else $error("Stop interrupt time-out missed");

  stop_no_reset_a: assert property (
    (timeout && stop_mode_i) |=> !sys_reset_o)
    else $error("Reset pulse during stop time-out");

  reset_no_irq_a: assert property (
    response_reset_i |=> !irq_o)
    else $error("Interrupt raised in reset mode");

  timeout_zero_a: assert property (
    timeout |=> count == 24'h000000)
    else $error("Time-out without zero count");

  flag_source_a: assert property (
    $rose(st.tmo_flag) |-> $past(timeout))
    else $error("Flag set without time-out");

  irq_level_a: assert property (
    (irq_o && !response_reset_i && !(rd_i && addr_i == `WD_ADDR_CTL))
      |=> irq_o)
    else $error("Interrupt dropped without status read");

  status_read_a: assert property (
    (rd_i && addr_i == `WD_ADDR_CTL)
      |=> rdata_o[`WD_STAT_TMO] == $past(st.tmo_flag)
      && rdata_o[`WD_STAT_STOP] == $past(st.stop_flag))
    else $error("Status read gave wrong flags");

  unlock_no_bits_a: assert property (
    (wr_i && addr_i == `WD_ADDR_CTL && !rd_i && !timeout)
      |=> $stable(st.tmo_flag) && $stable(st.stop_flag))
    else $error("Control write changed status bits");

  byte_order_a: assert property (
    (wr_i && st.lock == watchdog_pkg::LK_UPPER
      && addr_i == `WD_ADDR_UPPER)
      |=> st.reload[23:16] == $past(wdata_i)
      && st.lock == watchdog_pkg::LK_HIGH)
    else $error("Upper reload byte not taken");

  stray_relock_a: assert property (
    (wr_i && st.lock == watchdog_pkg::LK_UPPER
      && addr_i != `WD_ADDR_UPPER && addr_i != `WD_ADDR_CTL)
      |=> st.lock == watchdog_pkg::LK_IDLE)
    else $error("Stray write did not relock");

  relock_after_low_a: assert property (
    (wr_i && st.lock == watchdog_pkg::LK_LOW)
      |=> st.lock inside {watchdog_pkg::LK_IDLE, watchdog_pkg::LK_GOT55})
    else $error("Sequence stayed open after low byte");

  first_load_a: assert property (
    (refresh_i && !st.enabled) |=> st.enabled && count == $past(st.reload))
    else $error("First enable did not load");

endmodule

// [verif/reset_partner.sv]
module reset_partner (
  input  wire logic clk_i,
  input  wire logic sys_reset_i,
  input  wire logic stop_recovery_i,
  output int        resets_o,
  output int        recoveries_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_i) begin
    if (sys_reset_i === 1'b1)
      resets_o <= resets_o + 1;
    if (stop_recovery_i === 1'b1)
      recoveries_o <= recoveries_o + 1;
  end
endmodule

// [verif/watchdog_down_counter_test.sv]
module watchdog_down_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, refresh_i = 0, debug_i = 0;
  logic        stop_mode_i = 0, always_on_i = 0, response_reset_i = 0;
  logic        wr_i = 0, rd_i = 0, irq_o, sys_reset_o;
  logic        stop_recovery_o, enabled_o;
  logic [11:0] addr_i = 0;
  logic [7:0]  wdata_i = 0, rdata_o, rv;
  int          mismatches = 0, cmp_count = 0, resets, recs, rl, rb, n;

  always #20 clk_i = ~clk_i;

  watchdog_down_counter #(.TICK_CYCLES(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .refresh_i(refresh_i),
    .debug_i(debug_i), .stop_mode_i(stop_mode_i),
    .always_on_i(always_on_i), .response_reset_i(response_reset_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .sys_reset_o(sys_reset_o),
    .stop_recovery_o(stop_recovery_o), .enabled_o(enabled_o));

  reset_partner partner (
    .clk_i(clk_i), .sys_reset_i(sys_reset_o),
    .stop_recovery_i(stop_recovery_o), .resets_o(resets),
    .recoveries_o(recs));

  task tally_and_finish;
    $display("Counts: %0d mismatches, %0d compares", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1;
    @(negedge clk_i);
    wr_i = 0;
  endtask

  task rd(input logic [11:0] a);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1;
    @(negedge clk_i);
    rd_i = 0;
    @(negedge clk_i);
    rv = rdata_o;
  endtask

  task refresh;
    @(negedge clk_i);
    refresh_i = 1;
    @(negedge clk_i);
    refresh_i = 0;
  endtask

  task load(input int v);
    wr(12'hff0, 8'h55);
    wr(12'hff0, 8'haa);
    wr(12'hff1, v[23:16]);
    wr(12'hff2, v[15:8]);
    wr(12'hff3, v[7:0]);
  endtask

  task chk_low(input string m);
    rd(12'hff3);
    chk(rv === 8'(rl) || rv === 8'(rl - 1), m);
  endtask

  task wait_ev(input int sel);
    int b;
    b = (sel == 1) ? resets : recs;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_i);
      if (sel == 0 ? irq_o === 1'b1 : ((sel == 1) ? resets : recs) != b)
        return;
    end
    chk(1'b0, "wait timed out");
    tally_and_finish;
  endtask

  initial begin
    void'($urandom(9496));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 0;
    repeat (3) @(negedge clk_i);
    chk(enabled_o === 1'b0, "running without refresh");
    rd(12'hff1);
    chk(rv === 8'h00, "count not zero");
    rl = 'h10 + $urandom % 16;
    load(rl);
    refresh;
    chk(enabled_o === 1'b1, "not enabled");
    chk_low("first load");
    wr(12'hff0, 8'h55);
    wr(12'hff0, 8'haa);
    wr(12'h100, 8'h00);
    wr(12'hff1, 8'h77);
    refresh;
    rd(12'hff1);
    chk(rv === 8'h00, "write after stray");
    rd(12'hff0);
    chk(rv === 8'h00, "status after unlock");
    rd(12'h100);
    chk(rv === 8'h00, "unmapped read");
    wait_ev(0);
    chk(resets === 0, "reset in irq mode");
    repeat (8) @(negedge clk_i);
    rd(12'hff1);
    chk(rv === 8'hff, "no wrap");
    rd(12'hff0);
    chk(rv === 8'h80 && irq_o === 1'b0, "status read");
    response_reset_i = 1;
    refresh;
    wait_ev(1);
    chk(irq_o === 1'b0, "irq in reset mode");
    rd(12'hff0);
    chk(rv === 8'h80, "reset status");
    stop_mode_i = 1;
    rb = resets;
    refresh;
    wait_ev(2);
    rd(12'hff0);
    chk(rv === 8'h90 && resets === rb, "stop reset");
    response_reset_i = 0;
    refresh;
    wait_ev(2);
    chk(irq_o === 1'b1, "stop irq");
    rd(12'hff0);
    chk(rv === 8'h90, "stop status");
    stop_mode_i = 0;
    debug_i = 1;
    repeat (200) @(negedge clk_i);
    chk_low("debug refresh");
    debug_i = 0;
    refresh;
    repeat (6) begin
      repeat (40) @(negedge clk_i);
      refresh;
    end
    chk(irq_o === 1'b0, "refresh ignored");
    n = 0;
    rv = 8'hff;
    while (rv > 8'h02 && n < 100) begin
      rd(12'hff3);
      n++;
    end
    chk(rv <= 8'h02, "count never reached two");
    refresh;
    repeat (16) @(negedge clk_i);
    chk(irq_o === 1'b1, "late refresh reloaded");
    rd(12'hff0);
    chk(rv === 8'h80, "late time-out status");
    always_on_i = 1;
    rst_i = 1;
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    @(negedge clk_i);
    chk(enabled_o === 1'b1, "always-on not running");
    rd(12'hff2);
    chk(rv === 8'h04 || rv === 8'h03, "always-on load");
    tally_and_finish;
  end
endmodule
